/* File: dv/vbi_window_timing_control_bench.sv */
// Self-checking bench of the VBI window bank.
// Assumes package, bank and checker compiled first.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin miscompares++; $display("[FAIL] %0t mismatch", $time); end end
module vbi_window_timing_control_bench;
  import vwtc_pkg::*;
  logic clk = 1'b0, rst = 1'b1, ps = 1'b0, pe = 1'b0, pw = 1'b0, ce = 1'b1;
  logic [15:0] pa = 16'h0000;
  logic [31:0] pd = 32'h0000_0000;
  vwtc_vid_t vid = '0;
  logic rdy, err, ev, win, sl, qual, fo, scan, vp, dec;
  logic [31:0] rdat, rv;
  logic [11:0] plen, lo, hi, r;
  int miscompares = 0;
  int num_checks = 0;
  int cyc = 0;
  logic [11:0] dflt[6] = '{12'h0110, 12'h011b, 12'h000a, 12'h0015, 12'h0000, 12'h0000};
  // Clock enable driven by the bench so the freeze can be checked
  vwtc_top dut (.i_mclk(clk), .i_sys_rst(rst), .i_ce(ce), .i_psel(ps), .i_penable(pe), .i_pwrite(pw),
    .i_paddr(pa), .i_pwdata(pd), .i_vid(vid), .o_pready(rdy), .o_pslverr(err), .o_prdata(rdat),
    .o_in_vbi_window(win), .o_vbi_sliced(sl), .o_vbi_pkg_len(plen), .o_active_video_qualifier(qual),
    .o_field_odd(fo), .o_scan_mode(scan), .o_active_video_qualifier_prog_len(vp), .o_decim_latch(dec));
  always #5 clk = ~clk;
  // Hang guard, far above the few hundred cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      complete_run();
    end
  end
  task automatic complete_run();
    if (miscompares == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run
  // Setup, then access held until ready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    ps <= 1'b1;
    pe <= 1'b0;
    pw <= w;
    pa <= {2'b00, a, 2'b00};
    pd <= d;
    @(posedge clk);
    pe <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    rv = rdat;
    ev = err;
    ps <= 1'b0;
    pe <= 1'b0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [11:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK({ev, rv}, {1'b0, 20'h0_0000, e})
  endtask : rd
  // Both bounds count as inside
  function automatic logic inw(input logic [11:0] l, a, b);
    return l >= a && l <= b;
  endfunction : inw
  // Walk lines 0 to 39 with the input qualifier high
  task automatic sweep(input logic [11:0] a, b, input logic en, bl);
    for (int l = 0; l < 40; l++) begin
      @(posedge clk);
      vid.line_num <= 12'(l);
      repeat (2) @(posedge clk);
      `CHK(win, en & inw(12'(l), a, b))
      `CHK(qual, !(en & bl & inw(12'(l), a, b)))
    end
  endtask : sweep
  task automatic fld(input logic o);
    @(posedge clk);
    vid.field_odd <= o;
    vid.field_start <= 1'b1;
    @(posedge clk);
    vid.field_start <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : fld
  // Main sequence
  initial begin
    r = 12'($urandom(93));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    vid.active_video <= 1'b1;
    for (int i = 0; i < 6; i++) rd(12'h0134 + 12'(i), dflt[i]);
    rd(12'h0140, 12'h000);
    rd(12'h0141, 12'h000);
    // Window control skipped: its latch bit clears
    for (int i = 0; i < 6; i++) if (i != 4) begin
      r = 12'($urandom);
      apb(1'b1, 12'h0134 + 12'(i), {20'($urandom), r});
      rd(12'h0134 + 12'(i), r);
    end
    apb(1'b0, 12'h0142, 32'h0000_0000);
    `CHK({ev, rv}, {1'b1, 32'h0000_0000})
    apb(1'b1, 12'h0141, 32'h0000_0fff);
    rd(12'h0141, 12'h000);
    // Odd window at random bounds; control writes keep reserved bits zero
    lo = 12'(5 + $urandom_range(10));
    hi = lo + 12'($urandom_range(15));
    apb(1'b1, 12'h0140, 32'h0000_0100);
    fld(1'b1);
    `CHK(fo, 1'b1)
    apb(1'b1, 12'h0136, {20'h0_0000, lo});
    apb(1'b1, 12'h0137, {20'h0_0000, hi});
    apb(1'b1, 12'h0138, 32'h0000_0005);
    sweep(lo, hi, 1'b0, 1'b1);
    apb(1'b1, 12'h0138, 32'h0000_0805);
    rd(12'h0138, 12'h005);
    sweep(lo, hi, 1'b1, 1'b1);
    apb(1'b1, 12'h0136, 32'h0000_0000);
    apb(1'b1, 12'h0140, 32'h0000_0140);
    rd(12'h0140, 12'h100);
    sweep(12'h000, hi, 1'b1, 1'b1);
    // Filter on: no input toggle, so the field flips itself
    apb(1'b1, 12'h0140, 32'h0000_0000);
    fld(1'b1);
    `CHK(fo, 1'b0)
    `CHK(plen, 12'h0474)
    apb(1'b1, 12'h0139, 32'h0000_0000);
    apb(1'b1, 12'h0138, 32'h0000_0803);
    repeat (3) @(posedge clk);
    `CHK({sl, plen}, 13'h1040)
    apb(1'b1, 12'h0140, 32'h0000_0006);
    rd(12'h0141, 12'h000);
    apb(1'b1, 12'h0140, 32'h0000_0806);
    rd(12'h0141, 12'h006);
    `CHK({scan, vp}, 2'b11)
    rd(12'h0140, 12'h006);
    apb(1'b1, 12'h0140, 32'h0000_0400);
    for (int k = 0; k < 5 && dec !== 1'b1; k++) @(posedge clk);
    `CHK(dec, 1'b1)
    apb(1'b1, 12'h0140, 32'h0000_0080);
    repeat (3) @(posedge clk);
    `CHK(qual, 1'b0)
    // Clock enable low: a toggling field start must not move the field
    @(posedge clk);
    ce <= 1'b0;
    vid.field_odd <= 1'b0;
    vid.field_start <= 1'b1;
    @(posedge clk);
    vid.field_start <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK(fo, 1'b0)
    ce <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK(fo, 1'b0)
    complete_run();
  end
endmodule : vbi_window_timing_control_bench
`default_nettype wire

/* File: dv/vwtc_monitor.sv */
// Checker on the ports of the VBI window bank.
// Assumes vwtc_pkg compiled first; bound onto vwtc_top.
`timescale 1ns/100ps
`default_nettype none
module vwtc_monitor (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic [15:0] i_paddr,
  input wire vwtc_pkg::vwtc_vid_t i_vid,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic o_vbi_sliced,
  input wire logic [11:0] o_vbi_pkg_len,
  input wire logic o_active_video_qualifier,
  input wire logic o_field_odd,
  input wire logic o_decim_latch
);
  import vwtc_pkg::*;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  wire su = i_psel && !i_penable && i_ce;
  // Answer one cycle after setup, one cycle long
  ready_after_setup_a: assert property (su |=> o_pready) else $error("no ready");
  ready_one_a: assert property (o_pready && i_ce |=> !o_pready) else $error("long ready");
  mapped_no_error_a: assert property (
    su && i_paddr[13:2] inside {[12'h0134:12'h0139], 12'h0140, 12'h0141} |=> !o_pslverr) else $error("error");
  // A zero size must never reach the output
  raw_length_a: assert property (!o_vbi_sliced |-> o_vbi_pkg_len == 12'h0474) else $error("raw len");
  slice_length_a: assert property (o_vbi_sliced |-> o_vbi_pkg_len != 12'h0000) else $error("len");
  // Outputs may only drop the qualifier, never invent it
  qual_cause_a: assert property (
    o_active_video_qualifier && $past(i_ce) |-> $past(i_vid.active_video)) else $error("qualifier");
  decim_pulse_a: assert property (o_decim_latch && i_ce |=> !o_decim_latch) else $error("pulse");
  field_change_a: assert property ($changed(o_field_odd) |-> $past(i_vid.field_start))
    else $error("field");
  // Main scenarios
  cover property (o_pslverr);
  cover property (o_decim_latch);
  cover property (o_vbi_sliced && o_vbi_pkg_len == 12'h0040);
endmodule : vwtc_monitor
bind vwtc_top vwtc_monitor mon (.i_mclk, .i_sys_rst, .i_ce, .i_psel, .i_penable, .i_paddr, .i_vid,
  .o_pready, .o_pslverr, .o_vbi_sliced, .o_vbi_pkg_len, .o_active_video_qualifier, .o_field_odd, .o_decim_latch);
`default_nettype wire

/* File: hdl/vwtc_consts.svh */
// Constants of the VBI window and timing control bank.
// Assumes inclusion by bare name from hdl/.
`ifndef VWTC_CONSTS_SVH
`define VWTC_CONSTS_SVH
// Register indices; byte address is four times the index
`define VWTC_IDX_EVEN_FIRST 12'h0134
`define VWTC_IDX_EVEN_LAST 12'h0135
`define VWTC_IDX_ODD_FIRST 12'h0136
`define VWTC_IDX_ODD_LAST 12'h0137
`define VWTC_IDX_WIN_CTRL 12'h0138
`define VWTC_IDX_SLICE_SIZE 12'h0139
`define VWTC_IDX_TIMING_CTRL 12'h0140
`define VWTC_IDX_STATE_RPT 12'h0141
// Reset values
`define VWTC_RST_EVEN_FIRST 12'h0110
`define VWTC_RST_EVEN_LAST 12'h011b
`define VWTC_RST_ODD_FIRST 12'h000a
`define VWTC_RST_ODD_LAST 12'h0015
`define VWTC_RST_WIN_CTRL 12'h0000
`define VWTC_RST_SLICE_SIZE 12'h0000
`define VWTC_RST_TIMING_CTRL 12'h0060
// Window control fields
`define VWTC_WC_ENABLE 0
`define VWTC_WC_SLICED 1
`define VWTC_WC_BLANK 2
`define VWTC_WC_LATCH 11
// Timing control fields
`define VWTC_TC_SCAN 1
`define VWTC_TC_ACTIVE_VIDEO_QUALIFIER_PROG 2
`define VWTC_TC_WIN_ONE 5
`define VWTC_TC_WIN_TWO 6
`define VWTC_TC_ACTIVE_VIDEO_QUALIFIER_OFF 7
`define VWTC_TC_OEF_OFF 8
`define VWTC_TC_DECIM 10
`define VWTC_TC_TIMING 11
// Sliced package default size and raw sample count
`define VWTC_SLICE_DEFAULT 12'h0040
`define VWTC_RAW_SAMPLES 12'h0474
`endif

/* File: hdl/vwtc_pkg.sv */
// Types of the VBI window and timing control bank.
// Assumes vwtc_consts.svh for all numeric values.
package vwtc_pkg;
  // One field's window bounds
  typedef struct packed {
    logic [11:0] first;
    logic [11:0] last;
  } vwtc_win_t;
  // Window mode bits in force
  typedef struct packed {
    logic enable;
    logic sliced;
    logic blank;
  } vwtc_mode_t;
  // Video timing inputs from the decoder
  typedef struct packed {
    logic [11:0] line_num;
    logic field_odd;
    logic field_start;
    logic active_video;
  } vwtc_vid_t;
  // Whole state of the bank
  typedef struct packed {
    vwtc_win_t sh_even;
    vwtc_win_t sh_odd;
    logic [11:0] win_ctrl;
    logic [11:0] slice_size;
    logic [11:0] tim_ctrl;
    vwtc_win_t act_even;
    vwtc_win_t act_odd;
    vwtc_mode_t act_mode;
    logic act_scan;
    logic act_active_video_qualifier_prog;
    logic prev_field_in;
    logic field_out;
    logic in_window;
    logic qualifier;
    logic sliced_out;
    logic decim_pulse;
    logic [11:0] pkg_len;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } vwtc_state_t;
endpackage : vwtc_pkg

/* File: hdl/vwtc_top.sv */
// VBI window and timing control register bank with APB slave.
// Assumes a decoder that supplies line number, field and qualifier
// synchronous to i_mclk, and an APB master on the same clock.
//
// Overview of operation
// - Even-field first window line, frame-relative, resets to 272.
// - Even-field last window line, frame-relative, resets to 283.
// - Odd-field first window line resets to 10.
// - Odd-field last window line resets to 21.
// - Window acts only while window enable bit 0 is set.
// - Mode bit: 0 raw 1140 samples, 1 sliced 64-byte packages.
// - Ident bit: 0 qualifier active in window, 1 suppressed.
// - Window settings apply when update latch bit 11 written; bounds also on control bits 5 and 6.
// - Slice size 0 means 64; register resets to 0.
// - Control bit 1: 0 open timing mode, 1 scan mode.
// - Control bit 2: qualifier length from window or programmable.
// - Window latch bits 5 and 6 latch, self-clear, reset to 1.
// - General disable bit 7 suppresses the qualifier entirely.
// - Filter on: field follows input toggle, flips itself when input does not toggle; off: follow input.
// - Decimation frame count updates only on bit 10 write; self-clears.
// - Timing mode applies only on bit 11 write; self-clears.
// - Report word shows timing mode in force on bits 1 and 2.
`include "vwtc_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module vwtc_top #(
  parameter int LINE_W = 12
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [15:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire vwtc_pkg::vwtc_vid_t i_vid,
  output logic o_pready,
  output logic o_pslverr,
  output logic [31:0] o_prdata,
  output logic o_in_vbi_window,
  output logic o_vbi_sliced,
  output logic [11:0] o_vbi_pkg_len,
  output logic o_active_video_qualifier,
  output logic o_field_odd,
  output logic o_scan_mode,
  output logic o_active_video_qualifier_prog_len,
  output logic o_decim_latch
);
  import vwtc_pkg::*;

  // Line counters are held at the documented register width
  initial begin
    if (LINE_W != 12) begin
      $error("vwtc_top: LINE_W must be 12");
    end
  end

  // Map a byte address to a register index
  function automatic logic [11:0] idx_of(input logic [15:0] a);
    idx_of = a[13:2];
  endfunction : idx_of

  // True for any index the bank answers without an error
  function automatic logic mapped(input logic [11:0] i);
    mapped = (i >= `VWTC_IDX_EVEN_FIRST && i <= `VWTC_IDX_SLICE_SIZE) ||
             i == `VWTC_IDX_TIMING_CTRL || i == `VWTC_IDX_STATE_RPT;
  endfunction : mapped

  // Inclusive range test against one field's bounds
  function automatic logic in_range(input logic [11:0] n,
                                    input vwtc_win_t w);
    in_range = (n >= w.first) && (n <= w.last);
  endfunction : in_range

  vwtc_state_t s_reg;
  vwtc_state_t s_next;
  logic [11:0] idx;
  logic wr_now;
  logic setup;
  logic [11:0] wd;
  logic [11:0] rd;
  logic hit;
  logic q_next;

  // Decode of the current APB request
  assign idx = idx_of(i_paddr);
  assign setup = i_psel && !i_penable;
  // Write lands at the access edge where pready is seen high
  assign wr_now = i_psel && i_penable && s_reg.pready &&
                  i_pwrite && mapped(idx);
  assign wd = i_pwdata[11:0];

  // Read multiplexer; the report word shows latched timing modes
  always_comb begin
    rd = 12'h0000;
    unique case (idx)
      `VWTC_IDX_EVEN_FIRST: rd = s_reg.sh_even.first;
      `VWTC_IDX_EVEN_LAST: rd = s_reg.sh_even.last;
      `VWTC_IDX_ODD_FIRST: rd = s_reg.sh_odd.first;
      `VWTC_IDX_ODD_LAST: rd = s_reg.sh_odd.last;
      `VWTC_IDX_WIN_CTRL: rd = s_reg.win_ctrl;
      `VWTC_IDX_SLICE_SIZE: rd = s_reg.slice_size;
      `VWTC_IDX_TIMING_CTRL: rd = s_reg.tim_ctrl;
      `VWTC_IDX_STATE_RPT: begin
        rd[`VWTC_TC_SCAN] = s_reg.act_scan;
        rd[`VWTC_TC_ACTIVE_VIDEO_QUALIFIER_PROG] = s_reg.act_active_video_qualifier_prog;
      end
      default: rd = 12'h0000;
    endcase
  end

  // Window hit for the current field using settings in force
  always_comb begin
    hit = s_reg.field_out ?
          in_range(i_vid.line_num, s_reg.act_odd) :
          in_range(i_vid.line_num, s_reg.act_even);
    hit = hit && s_reg.act_mode.enable;
  end

  // Qualifier: general disable beats window blanking
  always_comb begin
    q_next = i_vid.active_video;
    if (hit && s_reg.act_mode.blank) begin
      q_next = 1'b0;
    end
    if (s_reg.tim_ctrl[`VWTC_TC_ACTIVE_VIDEO_QUALIFIER_OFF]) begin
      q_next = 1'b0;
    end
  end

  // Next-state logic for the whole bank
  always_comb begin
    s_next = s_reg;
    s_next.decim_pulse = 1'b0;

    // Self-clearing latch bits act one cycle after being set
    if (s_reg.win_ctrl[`VWTC_WC_LATCH]) begin
      s_next.act_even = s_reg.sh_even;
      s_next.act_odd = s_reg.sh_odd;
      s_next.act_mode.enable = s_reg.win_ctrl[`VWTC_WC_ENABLE];
      s_next.act_mode.sliced = s_reg.win_ctrl[`VWTC_WC_SLICED];
      s_next.act_mode.blank = s_reg.win_ctrl[`VWTC_WC_BLANK];
      s_next.win_ctrl[`VWTC_WC_LATCH] = 1'b0;
    end
    if (s_reg.tim_ctrl[`VWTC_TC_WIN_ONE]) begin
      s_next.act_even = s_reg.sh_even;
      s_next.tim_ctrl[`VWTC_TC_WIN_ONE] = 1'b0;
    end
    if (s_reg.tim_ctrl[`VWTC_TC_WIN_TWO]) begin
      s_next.act_odd = s_reg.sh_odd;
      s_next.tim_ctrl[`VWTC_TC_WIN_TWO] = 1'b0;
    end
    if (s_reg.tim_ctrl[`VWTC_TC_DECIM]) begin
      s_next.decim_pulse = 1'b1;
      s_next.tim_ctrl[`VWTC_TC_DECIM] = 1'b0;
    end
    if (s_reg.tim_ctrl[`VWTC_TC_TIMING]) begin
      s_next.act_scan = s_reg.tim_ctrl[`VWTC_TC_SCAN];
      s_next.act_active_video_qualifier_prog = s_reg.tim_ctrl[`VWTC_TC_ACTIVE_VIDEO_QUALIFIER_PROG];
      s_next.tim_ctrl[`VWTC_TC_TIMING] = 1'b0;
    end

    // Register writes come last so a new latch request is never lost
    if (wr_now) begin
      unique case (idx)
        `VWTC_IDX_EVEN_FIRST: s_next.sh_even.first = wd;
        `VWTC_IDX_EVEN_LAST: s_next.sh_even.last = wd;
        `VWTC_IDX_ODD_FIRST: s_next.sh_odd.first = wd;
        `VWTC_IDX_ODD_LAST: s_next.sh_odd.last = wd;
        `VWTC_IDX_WIN_CTRL: s_next.win_ctrl = wd;
        `VWTC_IDX_SLICE_SIZE: s_next.slice_size = wd;
        `VWTC_IDX_TIMING_CTRL: s_next.tim_ctrl = wd;
        default: s_next.win_ctrl = s_next.win_ctrl; // Report is read-only
      endcase
    end

    // Field identity filter, evaluated at each field start
    if (i_vid.field_start) begin
      s_next.prev_field_in = i_vid.field_odd;
      if (s_reg.tim_ctrl[`VWTC_TC_OEF_OFF]) begin
        s_next.field_out = i_vid.field_odd;
      end else if (i_vid.field_odd != s_reg.prev_field_in) begin
        s_next.field_out = i_vid.field_odd;
      end else begin
        // Input stuck: freewheel so fields keep alternating
        s_next.field_out = ~s_reg.field_out;
      end
    end

    // Output stage, all registered
    s_next.in_window = hit;
    s_next.qualifier = q_next;
    s_next.sliced_out = s_reg.act_mode.sliced;
    // Raw passes the full sample count; sliced uses the package size
    if (!s_reg.act_mode.sliced) begin
      s_next.pkg_len = `VWTC_RAW_SAMPLES;
    end else if (s_reg.slice_size == 12'h0000) begin
      s_next.pkg_len = `VWTC_SLICE_DEFAULT;
    end else begin
      s_next.pkg_len = s_reg.slice_size;
    end

    // APB answer: data sampled in setup, ready for one access cycle
    s_next.pready = setup;
    s_next.pslverr = setup && !mapped(idx);
    if (setup) begin
      s_next.prdata = {20'h0_0000, rd};
    end
  end

  // State register with synchronous reset and clock enable
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      s_reg <= '0;
      s_reg.sh_even.first <= `VWTC_RST_EVEN_FIRST;
      s_reg.sh_even.last <= `VWTC_RST_EVEN_LAST;
      s_reg.sh_odd.first <= `VWTC_RST_ODD_FIRST;
      s_reg.sh_odd.last <= `VWTC_RST_ODD_LAST;
      s_reg.act_even.first <= `VWTC_RST_EVEN_FIRST;
      s_reg.act_even.last <= `VWTC_RST_EVEN_LAST;
      s_reg.act_odd.first <= `VWTC_RST_ODD_FIRST;
      s_reg.act_odd.last <= `VWTC_RST_ODD_LAST;
      s_reg.win_ctrl <= `VWTC_RST_WIN_CTRL;
      s_reg.slice_size <= `VWTC_RST_SLICE_SIZE;
      s_reg.tim_ctrl <= `VWTC_RST_TIMING_CTRL;
      s_reg.pkg_len <= `VWTC_RAW_SAMPLES;
    end else if (i_ce) begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state register
  assign o_pready = s_reg.pready;
  assign o_pslverr = s_reg.pslverr;
  assign o_prdata = s_reg.prdata;
  assign o_in_vbi_window = s_reg.in_window;
  assign o_vbi_sliced = s_reg.sliced_out;
  assign o_vbi_pkg_len = s_reg.pkg_len;
  assign o_active_video_qualifier = s_reg.qualifier;
  assign o_field_odd = s_reg.field_out;
  assign o_scan_mode = s_reg.act_scan;
  assign o_active_video_qualifier_prog_len = s_reg.act_active_video_qualifier_prog;
  assign o_decim_latch = s_reg.decim_pulse;
endmodule : vwtc_top

`default_nettype wire
